// ### hdl/power_mux_pkg.sv
`default_nettype none
package power_mux_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] INPUT_FET_CONTROL_ADDR = 8'h13;
  localparam int         PAIR2_EN_BIT           = 7;
  localparam int         PAIR1_EN_BIT           = 6;
  localparam int         FORCE_OFF_BIT          = 0;
  localparam int         PAIR1_PRESENT_BIT      = 4;
  localparam int         PAIR2_PRESENT_BIT      = 5;
  localparam logic [7:0] INPUT_FET_CONTROL_RST  = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DETECT_TIME_NS = 1000;
  localparam int DETECT_CYCLES  = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_DETECT = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_ON1    = 5'b00100,
    ST_ON2    = 5'b01000,
    ST_SWAP   = 5'b10000
  } mux_state_t;

  typedef struct packed {
    logic undervoltage;
    logic overvoltage;
    logic overcurrent;
  } input_fault_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage
`default_nettype wire

// ### hdl/dual_input_power_mux_ctrl.sv
`default_nettype none

// Functional notes
// - At power-on, sense each FET pair and record presence flags.
// - Both drive pins grounded: flags zero, enables zero, both gates low forever.
// - Only pair one found: flag1 set, flag2 clear, enable2 locked zero.
// - Single pair: enable1 set and pair one on when input one valid.
// - Both pairs found: both flags set, both enables host writable.
// - Two pairs: only first-valid input switched on, other held off.
// - A write setting both enables at once leaves the selection; only its force-off bit acts.
// - Active input one invalid: pair one off, then pair two on automatically.
// - Host swaps inputs by writing enable field 01b to 10b or reverse.
// - Second input stays selected when first returns; only host or loss of input two swaps back.
// - Enable bits read back the actual on or off state of each pair.
// - Overvoltage or overcurrent faults switch the pairs off.
// - With one valid input, writing 00b keeps it on; force-off needed.
// - With both inputs valid, 00 or force-off turns both pairs off.
// - Swap: incoming pair on only after rail drops; converter held meanwhile.
module dual_input_power_mux_ctrl
  import power_mux_pkg::*;
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_pair1_sense,
  input  wire logic         i_pair2_sense,
  input  wire input_fault_t i_first_input_sense,
  input  wire input_fault_t i_second_input_sense,
  input  wire logic         i_input1_present,
  input  wire logic         i_input2_present,
  input  wire logic         i_rail_present,
  input  wire reg_req_t     i_reg_req,
  output logic [7:0]        o_reg_rdata,
  output logic              o_input1_gate_drive,
  output logic              o_input2_gate_drive,
  output logic              o_converter_hold
);

  // ==========================================================
  // Input validity
  // A fault on either protect comparator blocks that input outright
  function automatic logic input_valid(input logic present, input input_fault_t f);
    input_valid = present & ~f.undervoltage & ~f.overvoltage & ~f.overcurrent;
  endfunction

  // A both-on request leaves the selection unchanged, so the two pairs can never overlap
  function automatic logic sel_legal(input logic [7:0] wdata);
    sel_legal = !(wdata[PAIR2_EN_BIT] && wdata[PAIR1_EN_BIT]);
  endfunction

  // An empty selection field asks for both pairs off
  function automatic logic sel_none(input logic [7:0] wdata);
    sel_none = !wdata[PAIR2_EN_BIT] && !wdata[PAIR1_EN_BIT];
  endfunction

  // Last count of the settling span before the drive pins are read
  function automatic logic detect_end(input logic [CNT_W-1:0] cnt);
    detect_end = (cnt == CNT_W'(DETECT_CYCLES - 1));
  endfunction

  logic valid1;
  logic valid2;
  logic protect_trip;

  // Validity and protective trip
  always_comb begin
    valid1       = input_valid(i_input1_present, i_first_input_sense);
    valid2       = input_valid(i_input2_present, i_second_input_sense);
    protect_trip = i_first_input_sense.overvoltage | i_second_input_sense.overvoltage
                 | i_first_input_sense.overcurrent | i_second_input_sense.overcurrent;
  end

  // ==========================================================
  // State
  mux_state_t       state_reg,    state_next;
  logic [CNT_W-1:0] cnt_reg,      cnt_next;
  logic             present1_reg, present1_next;
  logic             present2_reg, present2_next;
  logic             force_off_reg, force_off_next;
  logic             host_off_reg,  host_off_next;
  logic             target2_reg,  target2_next;
  logic [7:0]       rdata_reg,    rdata_next;
  logic             drv1_reg,     drv1_next;
  logic             drv2_reg,     drv2_next;
  logic             hold_reg,     hold_next;

  logic       wr_hit;
  logic       req1;
  logic       req2;
  logic       both_valid;

  // ==========================================================
  // Fitting detection
  // Each drive pin is read once, after a fixed settling span; a pin tied to
  // ground reads low and marks its pair absent for as long as power stays up
  always_comb begin
    cnt_next      = cnt_reg;
    present1_next = present1_reg;
    present2_next = present2_reg;
    if (state_reg == ST_DETECT) begin
      cnt_next = cnt_reg + 1'b1;
      if (detect_end(cnt_reg)) begin
        present1_next = i_pair1_sense;
        // Pair two alone is no supported fitting, so it reads as absent
        present2_next = i_pair2_sense & i_pair1_sense;
      end
    end
  end

  // Register the detection results; only a reset repeats the detection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg      <= '0;
      present1_reg <= 1'b0;
      present2_reg <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      present1_reg <= present1_next;
      present2_reg <= present2_next;
    end
  end

  // ==========================================================
  // Host requests
  // Force-off follows bit zero of every write to the control register, a
  // refused both-on write included; the interlock that keeps the pairs from
  // overlapping is kept by the selection logic below, not here
  always_comb begin
    force_off_next = force_off_reg;
    host_off_next  = host_off_reg;
    // Parking lapses once a source drops: the remaining one is reconnected
    if (!both_valid) begin
      host_off_next = 1'b0;
    end
    if (wr_hit) begin
      force_off_next = i_reg_req.wdata[FORCE_OFF_BIT];
      if (sel_legal(i_reg_req.wdata)) begin
        host_off_next = sel_none(i_reg_req.wdata) && both_valid;
      end
    end
  end

  // Register the host requests
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      force_off_reg <= 1'b0;
      host_off_reg  <= 1'b0;
    end else begin
      force_off_reg <= force_off_next;
      host_off_reg  <= host_off_next;
    end
  end

  // ==========================================================
  // Selection
  // Next-state logic for selection and gate drive
  always_comb begin
    state_next     = state_reg;
    target2_next   = target2_reg;
    hold_next      = 1'b0;
    wr_hit         = i_reg_req.wr && (i_reg_req.addr == INPUT_FET_CONTROL_ADDR);
    req1           = i_reg_req.wdata[PAIR1_EN_BIT];
    req2           = i_reg_req.wdata[PAIR2_EN_BIT];
    both_valid     = valid1 & valid2;

    unique case (state_reg)
      ST_DETECT: begin
        // Selection waits until both presence flags are settled
        if (detect_end(cnt_reg)) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // First valid input wins unless the host selected pair two; else pair two only starts if pair one is not ready.
        // A host park holds both off only while both inputs stay valid
        if (!force_off_reg && !protect_trip && !(host_off_reg && both_valid)) begin
          if (present1_reg && valid1 && !(target2_reg && present2_reg && valid2)) begin
            state_next = ST_ON1;
          end else if (present2_reg && valid2) begin
            state_next = ST_ON2;
          end
        end
        // Host selection written while idle
        if (wr_hit && !(req1 && req2)) begin
          if (req2 && present2_reg) begin
            target2_next = 1'b1;
          end else if (req1) begin
            target2_next = 1'b0;
          end
        end
      end
      ST_ON1: begin
        if (force_off_reg || protect_trip) begin
          state_next = ST_IDLE;
        end else if (!valid1) begin
          if (present2_reg && valid2) begin
            target2_next = 1'b1;
            state_next   = ST_SWAP;
          end else begin
            state_next = ST_IDLE;
          end
        end else if (wr_hit && !(req1 && req2)) begin
          if (req2 && present2_reg && valid2) begin
            target2_next = 1'b1;
            state_next   = ST_SWAP;
          end else if (!req1 && !req2 && both_valid) begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_ON2: begin
        if (force_off_reg || protect_trip) begin
          state_next = ST_IDLE;
        end else if (!valid2) begin
          if (present1_reg && valid1) begin
            target2_next = 1'b0;
            state_next   = ST_SWAP;
          end else begin
            state_next = ST_IDLE;
          end
        end else if (wr_hit && !(req1 && req2)) begin
          // Returning input one alone does not pull selection back
          if (req1 && valid1) begin
            target2_next = 1'b0;
            state_next   = ST_SWAP;
          end else if (!req1 && !req2 && both_valid) begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_SWAP: begin
        // Both gates off until the rail collapses, else the sources short;
        // the hold ends with the edge that switches the incoming pair on
        if (force_off_reg || protect_trip) begin
          state_next = ST_IDLE;
        end else if (!i_rail_present) begin
          state_next = target2_reg ? ST_ON2 : ST_ON1;
        end
      end
      default: begin
        state_next = ST_DETECT;
      end
    endcase

    // A pair that was never found keeps its gate low whatever the state
    drv1_next = (state_next == ST_ON1) && present1_next;
    drv2_next = (state_next == ST_ON2) && present2_next;
    // The converter waits for as long as neither pair feeds the rail in a swap
    if (state_next == ST_SWAP) begin
      hold_next = 1'b1;
    end
  end

  // Register the selection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= ST_DETECT;
      target2_reg <= 1'b0;
      drv1_reg    <= 1'b0;
      drv2_reg    <= 1'b0;
      hold_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      target2_reg <= target2_next;
      drv1_reg    <= drv1_next;
      drv2_reg    <= drv2_next;
      hold_reg    <= hold_next;
    end
  end

  // ==========================================================
  // Read-back
  // The enable bits report the gates as driven, so a swap or a fault that the
  // device makes on its own shows up here without host action
  always_comb begin
    rdata_next                    = 8'h00;
    rdata_next[PAIR2_EN_BIT]      = drv2_next;
    rdata_next[PAIR1_EN_BIT]      = drv1_next;
    rdata_next[PAIR2_PRESENT_BIT] = present2_next;
    rdata_next[PAIR1_PRESENT_BIT] = present1_next;
    rdata_next[FORCE_OFF_BIT]     = force_off_next;
  end

  // Register the read-back word
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= INPUT_FET_CONTROL_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    o_reg_rdata         = rdata_reg;
    o_input1_gate_drive = drv1_reg;
    o_input2_gate_drive = drv2_reg;
    o_converter_hold    = hold_reg;
  end

endmodule // dual_input_power_mux_ctrl
`default_nettype wire

// ### sim/power_mux_properties.sv
`default_nettype none
module power_mux_checker
  import power_mux_pkg::*;
(
  input wire logic         i_ref_clk,
  input wire logic         i_rst,
  input wire logic         i_pair1_sense,
  input wire logic         i_pair2_sense,
  input wire input_fault_t i_first_input_sense,
  input wire input_fault_t i_second_input_sense,
  input wire logic         i_input1_present,
  input wire logic         i_input2_present,
  input wire logic         i_rail_present,
  input wire reg_req_t     i_reg_req,
  input wire logic [7:0]   o_reg_rdata,
  input wire logic         o_input1_gate_drive,
  input wire logic         o_input2_gate_drive,
  input wire logic         o_converter_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic g1 = o_input1_gate_drive;
  wire logic g2 = o_input2_gate_drive;
  wire logic w13 = i_reg_req.wr && i_reg_req.addr == INPUT_FET_CONTROL_ADDR;
  // Overvoltage or overcurrent on either input
  wire logic flt = |{i_first_input_sense[1:0], i_second_input_sense[1:0]};
  // ==========================================
  // Gate relations; shoot-through is the hazard
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  detect_quiet_a: assert property ($fell(i_rst) |-> (!g1 && !g2) [*8])
    else $error("gate on in detect");
  never_both_a: assert property (!(g1 && g2))
    else $error("pairs overlap");
  absent_lock_a: assert property (g2 |-> o_reg_rdata[PAIR2_PRESENT_BIT])
    else $error("absent pair driven");
  fault_off_a: assert property (flt |=> !g1 && !g2)
    else $error("fault left a pair on");
  force_off_a: assert property (w13 && i_reg_req.wdata[0] |-> ##[1:3] !g1 && !g2)
    else $error("force off ignored");
  dual_ignored_a: assert property (w13 && i_reg_req.wdata == 8'hC0 && !flt |=> $stable({g1, g2}))
    else $error("both-on write acted");
  read_back_a: assert property ($rose(g2) |-> ##[0:2] o_reg_rdata[PAIR2_EN_BIT])
    else $error("enable bit stale");
  swap_hold_a: assert property (o_converter_hold |-> !g1 && !g2)
    else $error("pair on while held");
  rail_first_a: assert property ($rose(g2) |-> !$past(i_rail_present))
    else $error("pair on before rail drop");
endmodule // power_mux_checker
bind dual_input_power_mux_ctrl power_mux_checker CHK (.*);
`default_nettype wire

// ### sim/pair_model.sv
`default_nettype none
module pair_model
(
  input  wire logic i_ref_clk,
  input  wire logic i_src1,
  input  wire logic i_src2,
  input  wire logic i_gate1,
  input  wire logic i_gate2,
  output logic      o_rail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] bleed_reg = 2'h0;
  // ==========================================
  // Rail charges through an on pair, bleeds off slowly so swaps must wait
  always_ff @(posedge i_ref_clk) begin
    if ((i_gate1 && i_src1) || (i_gate2 && i_src2))
      bleed_reg <= 2'h3;
    else if (bleed_reg != 2'h0)
      bleed_reg <= bleed_reg - 2'h1;
  end
  assign o_rail = bleed_reg != 2'h0;
endmodule // pair_model
`default_nettype wire

// ### sim/dual_input_power_mux_ctrl_tb_top.sv
`default_nettype none
module dual_input_power_mux_ctrl_tb_top
  import power_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = INPUT_FET_CONTROL_ADDR;
  logic clk, rst = 1'b1, fit1 = 1'b0, fit2 = 1'b0, src1 = 1'b0, src2 = 1'b0, oc2 = 1'b0;
  logic        rail, g1, g2, hold;
  logic        held = 1'b0;
  logic [7:0]  rd;
  logic [31:0] lfsr = 32'hD642;
  reg_req_t    req = '0;
  int          failures = 0;
  int          num_checks = 0;
  // Undervoltage stands for an absent source
  wire input_fault_t f1 = {!src1, 2'b00};
  wire input_fault_t f2 = {!src2, 1'b0, oc2};
  pair_model far_side (.i_ref_clk(clk), .i_src1(src1), .i_src2(src2), .i_gate1(g1),
    .i_gate2(g2), .o_rail(rail));
  dual_input_power_mux_ctrl DUT (.i_ref_clk(clk), .i_rst(rst), .i_pair1_sense(fit1),
    .i_pair2_sense(fit2), .i_first_input_sense(f1), .i_second_input_sense(f2),
    .i_input1_present(src1), .i_input2_present(src2), .i_rail_present(rail),
    .i_reg_req(req), .o_reg_rdata(rd), .o_input1_gate_drive(g1),
    .o_input2_gate_drive(g2), .o_converter_hold(hold));
  // ==========================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // A swap must raise the converter hold at least once
  always @(posedge clk) begin
    if (hold)
      held <= 1'b1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // A both-on request keeps the selection
  function automatic logic [1:0] pick(input logic [1:0] cur, input logic [7:0] w);
    return (w[7:6] == 2'b11) ? cur : w[7:6];
  endfunction
  // Bounded wait, then gates and read-back must both agree
  task automatic settle(input logic [1:0] e);
    for (int n = 0; n < 40 && {g2, g1} !== e; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    check({4'h0, g2, g1, rd[7:6]}, {4'h0, e, e});
  endtask
  task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req.wr <= 1'b0;
    settle(e);
  endtask
  // Reset with a new fitting; detection runs its full length
  task automatic boot(input logic a, input logic b);
    {fit1, fit2, src1, src2, oc2, rst} <= {a, b, 4'b0001};
    repeat (2) @(posedge clk);
    check(rd, INPUT_FET_CONTROL_RST);
    rst <= 1'b0;
    repeat (DETECT_CYCLES + 4) @(posedge clk);
    check(rd & 8'h30, {2'b00, a & b, a, 4'h0});
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test;
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [1:0] cur;
    logic [7:0] w;
    boot(1'b0, 1'b0);
    src1 <= 1'b1;
    settle(2'b00);
    boot(1'b1, 1'b0);
    src1 <= 1'b1;
    settle(2'b01);
    op(CTL, 8'h80, 2'b01);
    op(CTL, 8'h00, 2'b01);
    op(CTL, 8'h01, 2'b00);
    op(CTL, 8'h00, 2'b01);
    boot(1'b1, 1'b1);
    src1 <= 1'b1;
    settle(2'b01);
    src2 <= 1'b1;
    settle(2'b01);
    op(CTL, 8'hC0, 2'b01);
    op(8'h12, 8'h80, 2'b01);
    op(CTL, 8'h80, 2'b10);
    check({6'h00, held, hold}, 8'h02);
    op(CTL, 8'h40, 2'b01);
    src1 <= 1'b0;
    settle(2'b10);
    src1 <= 1'b1;
    settle(2'b10);
    cur = 2'b10;
    // Random field writes, some to a neighbouring unmapped address
    repeat (40) begin
      lfsr = step(lfsr);
      w = {((lfsr[1:0] == 2'b00) ? 2'b11 : lfsr[1:0]), 6'h00};
      cur = lfsr[2] ? pick(cur, w) : cur;
      op(lfsr[2] ? CTL : 8'h12, w, cur);
    end
    op(CTL, 8'h00, 2'b00);
    op(CTL, 8'h80, 2'b10);
    oc2 <= 1'b1;
    settle(2'b00);
    end_of_test;
  end
endmodule // dual_input_power_mux_ctrl_tb_top
`default_nettype wire
